/* hdl/pao_pkg.sv */
// Package of register map, field positions and reset values of the oscillator.
package pao_pkg;

	// ----------------------------------------------------------------------
	// Register byte addresses on the bus
	// ----------------------------------------------------------------------
	localparam logic [7:0] PAO_OFF_CTRL = 8'h00;
	localparam logic [7:0] PAO_OFF_CLK = 8'h04;
	localparam logic [7:0] PAO_OFF_ACC_L = 8'h08;
	localparam logic [7:0] PAO_OFF_ACC_H = 8'h0C;
	localparam logic [7:0] PAO_OFF_ACC_U = 8'h10;
	localparam logic [7:0] PAO_OFF_STEP_L = 8'h14;
	localparam logic [7:0] PAO_OFF_STEP_H = 8'h18;
	localparam logic [7:0] PAO_OFF_STEP_U = 8'h1C;
	localparam logic [7:0] PAO_OFF_FLAG = 8'h20;

	// ----------------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------------
	localparam int PAO_BIT_ON = 7;
	localparam int PAO_BIT_LEVEL = 5;
	localparam int PAO_BIT_INV = 4;
	localparam int PAO_BIT_PFM = 0;
	localparam int PAO_PWS_LSB = 5;
	localparam int PAO_PWS_W = 3;
	localparam int PAO_CKS_W = 4;
	localparam int PAO_ACC_W = 20;
	localparam int PAO_UPPER_W = 4;
	localparam int PAO_CNT_W = 7;
	localparam int PAO_NSRC = 10;

	// ----------------------------------------------------------------------
	// Reset values and constants
	// ----------------------------------------------------------------------
	localparam logic [7:0] PAO_RST_BYTE = 8'h00;
	localparam logic [7:0] PAO_RST_STEP_L = 8'h01;
	localparam logic [PAO_CKS_W-1:0] PAO_CKS_SYS = 4'h0;
	localparam logic [PAO_CKS_W-1:0] PAO_CKS_LAST = 4'hA;
	localparam logic [PAO_CNT_W:0] PAO_ONE = 8'h01;
	localparam logic [23:0] PAO_RD_PAD = 24'h000000;
	localparam logic [1:0] PAO_HRESP_OKAY = 2'h0;

endpackage : pao_pkg

/* hdl/pao_clk_edge.sv */
// Input clock selector and edge detector for the oscillator.
module pao_clk_edge
#(
	parameter int NSRC = 10
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [pao_pkg::PAO_CKS_W-1:0] clock_source_sel,
	input wire logic [NSRC-1:0] src_levels,
	output logic rise,
	output logic fall
);
	import pao_pkg::*;

	logic prev_q;
	logic [15:0] lvl_table;
	wire logic sys_sel;
	wire logic reserved_sel;
	wire logic lvl;

	generate
		if (NSRC != PAO_NSRC)
		begin : g_bad
			$error("pao_clk_edge: source count must match clock select codes");
		end
	endgenerate

	// ----------------------------------------------------------------------
	// Source selection
	// ----------------------------------------------------------------------
	assign lvl_table = {{(16 - NSRC - 1){1'b0}}, src_levels, 1'b0};
	assign sys_sel = (clock_source_sel == PAO_CKS_SYS);
	// Reserved codes select no clock, so the accumulator stands still.
	assign reserved_sel = (clock_source_sel > PAO_CKS_LAST);
	assign lvl = lvl_table[clock_source_sel] & ~reserved_sel;

	// The system clock gives one rising and one falling tick every cycle.
	assign rise = sys_sel | (lvl & ~prev_q);
	assign fall = sys_sel | (~lvl & prev_q);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			prev_q <= 1'b0;
		else
			prev_q <= lvl;
	end

endmodule : pao_clk_edge

/* hdl/pao_osc.sv */
// Phase accumulator oscillator with its AHB-Lite register slave.
// --------------------------------------------------------------------------
// Summary of operation
// - The oscillator runs only while the enable bit is set.
// - A read-only status bit shows the present output level.
// - The polarity bit inverts the final output.
// - Mode bit set selects pulse mode, one active pulse per overflow.
// - Mode bit clear selects toggle mode, overflow rate divided by two.
// - Pulse width field gives two to the field value input periods.
// - Pulse width is used only in pulse mode.
// - Clock source field selects the input clock; high codes are reserved.
// - The accumulator spans three byte registers, only the low nibble of the upper one used.
// - The accumulator updates live; no atomic multi-byte access exists.
// - Step buffer loads on first falling input edge after low write; while stopped, at once after any step write.
// - Unimplemented bits read as zero.
// - All register bits reset to zero except step low bit 0.
// - Each rising input edge adds the step buffer to the accumulator.
// - Toggle mode flips the output on every overflow.
// - Pulse mode output goes active on the next rising input edge.
// - Every overflow sets a sticky flag that software clears.
// --------------------------------------------------------------------------
module pao_osc
#(
	parameter int NSRC = 10
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [1:0] hresp,
	output logic [31:0] hrdata,
	input wire logic [NSRC-1:0] src_levels,
	output logic osc_out
);
	import pao_pkg::*;

	// ----------------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------------
	logic osc_on_q;
	logic output_invert_q;
	logic pulse_mode_select_q;
	logic [PAO_PWS_W-1:0] pulse_width_sel_q;
	logic [PAO_CKS_W-1:0] clock_source_sel_q;
	logic [PAO_ACC_W-1:0] acc_q;
	logic [PAO_ACC_W-1:0] acc_d;
	logic [7:0] step_l_q;
	logic [7:0] step_h_q;
	logic [PAO_UPPER_W-1:0] step_u_q;
	logic [PAO_ACC_W-1:0] step_buffer_q;
	logic step_pend_q;
	logic ovf_pend_q;
	logic raw_q;
	logic raw_d;
	logic [PAO_CNT_W-1:0] pulse_cnt_q;
	logic [PAO_CNT_W-1:0] pulse_cnt_d;
	logic overflow_flag_q;
	logic osc_out_q;
	logic dp_wr_q;
	logic [7:0] dp_addr_q;
	logic [31:0] hrdata_q;
	logic hreadyout_q;
	logic [7:0] rd_byte;
	wire logic rise;
	wire logic fall;
	wire logic [PAO_ACC_W:0] sum;
	wire logic accumulator_carry;
	wire logic tick;
	wire logic take;
	wire logic take_rd;
	wire logic [7:0] wbyte;
	wire logic wr_ctrl;
	wire logic wr_clk;
	wire logic wr_acc_l;
	wire logic wr_acc_h;
	wire logic wr_acc_u;
	wire logic wr_acc;
	wire logic wr_step_l;
	wire logic wr_step_h;
	wire logic wr_step_u;
	wire logic wr_step;
	wire logic wr_flag;
	wire logic [PAO_ACC_W-1:0] step_value;
	wire logic [PAO_CNT_W-1:0] width_m1;
	wire logic pulse_start;
	wire logic pulse_end;
	wire logic load_now;
	wire logic load_edge;
	wire logic flag_clr;

	pao_clk_edge #(
		.NSRC(NSRC)
	) u_edge (
		.hclk(hclk),
		.hresetn(hresetn),
		.clock_source_sel(clock_source_sel_q),
		.src_levels(src_levels),
		.rise(rise),
		.fall(fall)
	);

	// ----------------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------------
	assign take = hsel & htrans[1] & hready;
	assign take_rd = take & ~hwrite;
	assign wbyte = hwdata[7:0];
	assign wr_ctrl = dp_wr_q & (dp_addr_q == PAO_OFF_CTRL);
	assign wr_clk = dp_wr_q & (dp_addr_q == PAO_OFF_CLK);
	assign wr_acc_l = dp_wr_q & (dp_addr_q == PAO_OFF_ACC_L);
	assign wr_acc_h = dp_wr_q & (dp_addr_q == PAO_OFF_ACC_H);
	assign wr_acc_u = dp_wr_q & (dp_addr_q == PAO_OFF_ACC_U);
	assign wr_acc = wr_acc_l | wr_acc_h | wr_acc_u;
	assign wr_step_l = dp_wr_q & (dp_addr_q == PAO_OFF_STEP_L);
	assign wr_step_h = dp_wr_q & (dp_addr_q == PAO_OFF_STEP_H);
	assign wr_step_u = dp_wr_q & (dp_addr_q == PAO_OFF_STEP_U);
	assign wr_step = wr_step_l | wr_step_h | wr_step_u;
	assign wr_flag = dp_wr_q & (dp_addr_q == PAO_OFF_FLAG);

	// Reads are sampled in the address phase so hrdata comes from a flop.
	// A read right after a write to the same register returns the old value.
	always_comb
	begin
		unique case (haddr[7:0])
			PAO_OFF_CTRL: rd_byte = {osc_on_q, 1'b0, osc_out_q,
				output_invert_q, 3'h0, pulse_mode_select_q};
			PAO_OFF_CLK: rd_byte = {pulse_width_sel_q, 1'b0,
				clock_source_sel_q};
			PAO_OFF_ACC_L: rd_byte = acc_q[7:0];
			PAO_OFF_ACC_H: rd_byte = acc_q[15:8];
			PAO_OFF_ACC_U: rd_byte = {4'h0, acc_q[19:16]};
			PAO_OFF_STEP_L: rd_byte = step_l_q;
			PAO_OFF_STEP_H: rd_byte = step_h_q;
			PAO_OFF_STEP_U: rd_byte = {4'h0, step_u_q};
			PAO_OFF_FLAG: rd_byte = {7'h00, overflow_flag_q};
			default: rd_byte = PAO_RST_BYTE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp_wr_q <= 1'b0;
			dp_addr_q <= PAO_RST_BYTE;
			hrdata_q <= 32'h00000000;
			hreadyout_q <= 1'b0;
		end
		else
		begin
			dp_wr_q <= take & hwrite;
			dp_addr_q <= haddr[7:0];
			hrdata_q <= take_rd ? {PAO_RD_PAD, rd_byte} : 32'h00000000;
			hreadyout_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------------
	// Control and step registers
	// ----------------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			osc_on_q <= 1'b0;
			output_invert_q <= 1'b0;
			pulse_mode_select_q <= 1'b0;
			pulse_width_sel_q <= 3'h0;
			clock_source_sel_q <= PAO_CKS_SYS;
			step_l_q <= PAO_RST_STEP_L;
			step_h_q <= PAO_RST_BYTE;
			step_u_q <= 4'h0;
		end
		else
		begin
			if (wr_ctrl)
			begin
				osc_on_q <= wbyte[PAO_BIT_ON];
				output_invert_q <= wbyte[PAO_BIT_INV];
				pulse_mode_select_q <= wbyte[PAO_BIT_PFM];
			end
			if (wr_clk)
			begin
				pulse_width_sel_q <= wbyte[PAO_PWS_LSB +: PAO_PWS_W];
				clock_source_sel_q <= wbyte[PAO_CKS_W-1:0];
			end
			if (wr_step_l)
				step_l_q <= wbyte;
			if (wr_step_h)
				step_h_q <= wbyte;
			if (wr_step_u)
				step_u_q <= wbyte[PAO_UPPER_W-1:0];
		end
	end

	// ----------------------------------------------------------------------
	// Step buffer
	// ----------------------------------------------------------------------
	assign step_value = {step_u_q, step_h_q, step_l_q};
	// Low-byte write arms the transfer so a half-written value is never used.
	assign load_now = ~osc_on_q & step_pend_q;
	assign load_edge = osc_on_q & step_pend_q & fall;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			step_buffer_q <= {{(PAO_ACC_W-1){1'b0}}, 1'b1};
			step_pend_q <= 1'b0;
		end
		else
		begin
			if (load_now | load_edge)
				step_buffer_q <= step_value;
			if (wr_step_l | (~osc_on_q & wr_step))
				step_pend_q <= 1'b1;
			else if (load_edge | load_now)
				step_pend_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------------
	// Accumulator and output stage
	// ----------------------------------------------------------------------
	assign tick = osc_on_q & rise;
	assign sum = {1'b0, acc_q} + {1'b0, step_buffer_q};
	assign accumulator_carry = sum[PAO_ACC_W];
	assign width_m1 = PAO_CNT_W'((PAO_ONE << pulse_width_sel_q) - PAO_ONE);
	assign pulse_start = tick & ovf_pend_q;
	assign pulse_end = tick & raw_q & (pulse_cnt_q == 7'h00);
	assign flag_clr = wr_flag & wbyte[0];

	always_comb
	begin
		acc_d = acc_q;
		if (wr_acc_l)
			acc_d[7:0] = wbyte;
		else if (wr_acc_h)
			acc_d[15:8] = wbyte;
		else if (wr_acc_u)
			acc_d[19:16] = wbyte[PAO_UPPER_W-1:0];
		else if (tick)
			acc_d = sum[PAO_ACC_W-1:0];
	end

	always_comb
	begin
		raw_d = raw_q;
		pulse_cnt_d = pulse_cnt_q;
		if (!osc_on_q)
			raw_d = 1'b0;
		else if (!pulse_mode_select_q)
		begin
			if (tick & accumulator_carry)
				raw_d = ~raw_q;
		end
		else if (pulse_start)
		begin
			raw_d = 1'b1;
			pulse_cnt_d = width_m1;
		end
		else if (pulse_end)
			raw_d = 1'b0;
		else if (tick & raw_q)
			pulse_cnt_d = pulse_cnt_q - 7'h01;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			acc_q <= {PAO_ACC_W{1'b0}};
			raw_q <= 1'b0;
			pulse_cnt_q <= 7'h00;
			ovf_pend_q <= 1'b0;
			overflow_flag_q <= 1'b0;
			osc_out_q <= 1'b0;
		end
		else
		begin
			acc_q <= acc_d;
			raw_q <= raw_d;
			pulse_cnt_q <= pulse_cnt_d;
			if (tick)
				ovf_pend_q <= accumulator_carry & pulse_mode_select_q;
			else if (!osc_on_q)
				ovf_pend_q <= 1'b0;
			// A new overflow wins over a clear in the same cycle.
			if (tick & accumulator_carry)
				overflow_flag_q <= 1'b1;
			else if (flag_clr)
				overflow_flag_q <= 1'b0;
			osc_out_q <= raw_q ^ output_invert_q;
		end
	end

	assign hreadyout = hreadyout_q;
	assign hresp = PAO_HRESP_OKAY;
	assign hrdata = hrdata_q;
	assign osc_out = osc_out_q;

	// ----------------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_pulse_go;
		osc_on_q && pulse_mode_select_q && pulse_start;
	endsequence

	sequence s_pulse_last;
		osc_on_q && pulse_mode_select_q && pulse_end && !ovf_pend_q;
	endsequence

	a_disabled_acc_hold: assert property (
		!osc_on_q && !wr_acc |=> acc_q == $past(acc_q))
		else $error("accumulator moved while disabled");

	a_acc_step_add: assert property (
		tick && !wr_acc |=> acc_q == $past(sum[PAO_ACC_W-1:0]))
		else $error("accumulator did not add the step buffer");

	a_toggle_on_carry: assert property (
		tick && accumulator_carry && !pulse_mode_select_q
		|=> raw_q != $past(raw_q))
		else $error("toggle mode output did not flip on overflow");

	a_pulse_width_load: assert property (
		s_pulse_go |=> raw_q && pulse_cnt_q == $past(width_m1))
		else $error("pulse did not start with the selected width");

	a_pulse_width_end: assert property (
		s_pulse_last ##1 osc_on_q |-> !raw_q)
		else $error("pulse did not end after its width");

	a_out_polarity: assert property (
		1'b1 |=> osc_out_q == ($past(raw_q) ^ $past(output_invert_q)))
		else $error("output polarity wrong");

	a_flag_sticky: assert property (
		tick && accumulator_carry |=> overflow_flag_q ##1 overflow_flag_q
		|| $past(flag_clr))
		else $error("overflow flag not set or lost");

	a_buf_edge_load: assert property (
		load_edge && !wr_step |=> step_buffer_q == $past(step_value))
		else $error("step buffer not loaded on falling edge");

	a_buf_now_load: assert property (
		load_now |=> step_buffer_q == $past(step_value))
		else $error("step buffer not loaded at once while disabled");

	a_rd_upper_zero: assert property (
		hrdata_q[31:8] == 24'h000000)
		else $error("unused read bits not zero");

endmodule : pao_osc

/* testbench/phase_accumulator_osc_test.sv */
// Self-checking testbench of the phase accumulator oscillator.
module phase_accumulator_osc_test;
	timeunit 1ns;
	timeprecision 100ps;
	import pao_pkg::*;

	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic hclk;
	logic hresetn;
	logic hsel;
	logic hwrite;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout;
	logic osc_out;
	logic [9:0] src_levels;
	logic inv_g;
	int n_fail;
	int check_count;
	int n_edge;
	int n_act;
	integer seed;
	logic [19:0] a0;
	logic [19:0] a1;
	logic [19:0] sa;
	logic [19:0] sb;
	logic [3:0] code;
	logic [7:0] ua [5] = '{8'h00, 8'h04, 8'h10, 8'h1C, 8'h24};
	logic [7:0] ue [5] = '{8'h31, 8'hEF, 8'h0F, 8'h0F, 8'h00};

	pao_osc #(.NSRC(PAO_NSRC)) dut_u (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(),
		.hrdata(hrdata), .src_levels(src_levels), .osc_out(osc_out)
	);

	initial
	begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic conclude();
		if (n_fail == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude

	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("FAIL %0t got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	// The master never counts on a latency; only the watchdog ends a wait.
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] r);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= w;
		hsize <= 3'b010;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h000000, d};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata[7:0];
		repeat (2) @(posedge hclk);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		bus(1'b1, a, d, r);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] r;
		bus(1'b0, a, 8'h00, r);
		chk({12'h000, r}, {12'h000, e});
	endtask : rd_chk

	task automatic rd_acc(output logic [19:0] v);
		logic [7:0] l;
		logic [7:0] h;
		logic [7:0] u;
		bus(1'b0, PAO_OFF_ACC_L, 8'h00, l);
		bus(1'b0, PAO_OFF_ACC_H, 8'h00, h);
		bus(1'b0, PAO_OFF_ACC_U, 8'h00, u);
		v = {u[3:0], h, l};
	endtask : rd_acc

	// Each tick is two cycles high, two low; unselected sources are noise.
	// All sources then rest low, so no stale level hides the next first edge.
	task automatic ticks(input int n, input logic [9:0] m);
		logic prev;
		prev = osc_out;
		n_edge = 0;
		n_act = 0;
		for (int i = 0; i < 4 * n + 8; i++)
		begin
			src_levels <= (i >= 4 * n) ? 10'h000
				: ((i % 4 < 2) ? m : 10'h000)
				| (10'($random(seed)) & ~m);
			@(posedge hclk);
			if (osc_out !== prev)
				n_edge++;
			if (osc_out !== inv_g)
				n_act++;
			prev = osc_out;
		end
	endtask : ticks

	function automatic logic [9:0] msk(input logic [3:0] c);
		return (c >= 4'h1 && c <= PAO_CKS_LAST) ? 10'(1) << (c - 1) : 10'h3FF;
	endfunction : msk

	function automatic longint sum_after(input logic [19:0] st, input int t);
		return longint'(st) * t;
	endfunction : sum_after

	task automatic setup(input logic [3:0] c, input logic p,
		input logic [2:0] w, input logic i, input logic [19:0] st);
		wr(PAO_OFF_CTRL, 8'h00);
		wr(PAO_OFF_ACC_L, 8'h00);
		wr(PAO_OFF_ACC_H, 8'h00);
		wr(PAO_OFF_ACC_U, 8'h00);
		wr(PAO_OFF_STEP_U, {4'h0, st[19:16]});
		wr(PAO_OFF_STEP_H, st[15:8]);
		wr(PAO_OFF_STEP_L, st[7:0]);
		wr(PAO_OFF_CLK, {w, 1'b0, c});
		wr(PAO_OFF_CTRL, {1'b1, 2'b00, i, 3'b000, p});
		inv_g = i;
	endtask : setup

	task automatic run_case(input logic [3:0] c, input logic p,
		input logic [2:0] w, input logic i, input logic [19:0] st,
		input int t);
		logic [19:0] acc;
		longint s;
		setup(c, p, w, i, st);
		ticks(t, msk(c));
		s = sum_after(st, t);
		rd_acc(acc);
		chk(acc, s[19:0]);
		if (p)
		begin
			chk(20'(n_edge), 20'h00004);
			chk(20'(n_act), 20'(8 << w));
		end
		else
			chk(20'(n_edge), 20'(s >> 20));
		chk({19'h0, osc_out}, {19'h0, i ^ (~p & s[20])});
		rd_chk(PAO_OFF_CTRL, {2'b10, i ^ (~p & s[20]), i, 3'b000, p});
		rd_chk(PAO_OFF_FLAG, {7'h00, (s >> 20) != 0});
		wr(PAO_OFF_FLAG, 8'h01);
		rd_chk(PAO_OFF_FLAG, 8'h00);
	endtask : run_case

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial
	begin
		seed = 32'hE88FA3EA;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h00000000;
		src_levels = 10'h000;
		inv_g = 1'b0;
		n_fail = 0;
		check_count = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int a = 0; a <= 36; a += 4)
			rd_chk(8'(a), {7'h00, 8'(a) == PAO_OFF_STEP_L});
		for (int k = 0; k < 5; k++)
		begin
			wr(ua[k], k == 0 ? 8'h7F : 8'hFF);
			rd_chk(ua[k], ue[k]);
		end
		chk({19'h0, osc_out}, 20'h00001);
		for (int w = 0; w < 8; w++)
			run_case(4'(1 + {$random(seed)} % 10), 1'b1, 3'(w),
				1'($random(seed)), 20'(1) << (18 - w), 3 << (w + 2));
		for (int c = 1; c <= 10; c++)
			run_case(4'(c), 1'b0, 3'($random(seed)), 1'($random(seed)),
				20'($random(seed)) | 20'h00001, 20 + {$random(seed)} % 40);
		// A stopped oscillator must neither count nor drive its output.
		code = 4'(1 + {$random(seed)} % 10);
		run_case(code, 1'b0, 3'h0, 1'b0, 20'h12345, 30);
		rd_acc(a0);
		wr(PAO_OFF_CTRL, 8'h00);
		ticks(10, msk(code));
		rd_acc(a1);
		chk(a1, a0);
		chk(20'(n_edge), 20'h00000);
		for (int c = 11; c <= 15; c++)
		begin
			setup(4'(c), 1'b0, 3'h0, 1'b0, 20'h80000);
			ticks(20, 10'h3FF);
			rd_acc(a0);
			chk(a0, 20'h00000);
		end
		// The system clock ticks every cycle: enable to stop spans four.
		sa = 20'($random(seed));
		setup(PAO_CKS_SYS, 1'b0, 3'h0, 1'b0, sa);
		wr(PAO_OFF_CTRL, 8'h00);
		rd_acc(a0);
		chk(a0, 20'(sum_after(sa, 4)));
		// Step change while running: only the low byte write arms the load.
		sa = 20'($random(seed));
		sb = 20'($random(seed));
		setup(code, 1'b0, 3'h0, 1'b0, sa);
		ticks(7, msk(code));
		wr(PAO_OFF_STEP_U, {4'h0, sb[19:16]});
		wr(PAO_OFF_STEP_H, sb[15:8]);
		ticks(5, msk(code));
		wr(PAO_OFF_STEP_L, sb[7:0]);
		ticks(9, msk(code));
		rd_acc(a0);
		chk(a0, 20'(sum_after(sa, 13) + sum_after(sb, 8)));
		conclude();
	end

	initial
	begin
		repeat (90000) @(posedge hclk);
		n_fail++;
		conclude();
	end

endmodule : phase_accumulator_osc_test
